/* shared/uefm_map.vh */
// Purpose: register offsets, fields and sizes for the endpoint fifo manager
// Assumes: apb with 32-bit data, one aligned word per register
// Notes: definitions only
`ifndef UEFM_MAP_VH
`define UEFM_MAP_VH
// register byte addresses
`define UEFM_EPC_BASE      12'h000
`define UEFM_EPS_BASE      12'h040
`define UEFM_INT_FLAGS     12'h080
`define UEFM_CMD           12'h084
`define UEFM_DMA_CFG       12'h088
`define UEFM_HW_CFG        12'h08C
`define UEFM_SER_EVT       12'h090
`define UEFM_ALLOC_TOTAL   12'h094
// endpoint config fields
`define UEFM_EPC_SIZE_LSB  0
`define UEFM_EPC_SIZE_MSB  3
`define UEFM_EPC_ISO       4
`define UEFM_EPC_DBLBUF    5
`define UEFM_EPC_DIR       6
`define UEFM_EPC_EN        7
// command fields: [3:0] endpoint, [6:4] opcode
`define UEFM_OP_READ       3'h1
`define UEFM_OP_WRITE      3'h2
`define UEFM_OP_CLEAR      3'h3
`define UEFM_OP_VALIDATE   3'h4
`define UEFM_OP_SETUP_ACK  3'h5
// dma config fields
`define UEFM_DMA_EN        0
`define UEFM_DMA_BURST     1
`define UEFM_DMA_IDX_LSB   4
`define UEFM_DMA_IDX_MSB   7
// hardware config fields
`define UEFM_HW_ACK_ONLY   0
`define UEFM_HW_REQ_HIGH   1
`define UEFM_HW_ACK_HIGH   2
`define UEFM_HW_FIN_HIGH   3
// serial engine event fields
`define UEFM_SER_EP_LSB    0
`define UEFM_SER_EP_MSB    3
`define UEFM_SER_PKT       4
`define UEFM_SER_SETUP     5
`define UEFM_SER_BUSRST    6
`define UEFM_SER_SHORT     7
// sizes
`define UEFM_CTRL_SIZE     12'h040
`define UEFM_MEM_BYTES     12'h99E
`define UEFM_BURST_MAX     5'h10
`define UEFM_NUM_EP        16
`endif

/* src/uefm_size_dec.v */
// Purpose: fifo size code to byte count, doubled when double-buffered
// Assumes: enable gates the size to zero
// Notes: reserved non-iso codes give zero bytes
`timescale 1ns/10ps
module uefm_size_dec (
    input  wire [3:0]  size_code,
    input  wire        iso,
    input  wire        dbl,
    input  wire        en,
    output reg  [11:0] phys_bytes
);
    reg [10:0] logical;
    always @* begin
        logical = 11'h000;
        if (iso) begin
            case (size_code)
                4'h0: logical = 11'd16;
                4'h1: logical = 11'd32;
                4'h2: logical = 11'd48;
                4'h3: logical = 11'd64;
                4'h4: logical = 11'd96;
                4'h5: logical = 11'd128;
                4'h6: logical = 11'd160;
                4'h7: logical = 11'd192;
                4'h8: logical = 11'd256;
                4'h9: logical = 11'd320;
                4'hA: logical = 11'd384;
                4'hB: logical = 11'd512;
                4'hC: logical = 11'd640;
                4'hD: logical = 11'd768;
                4'hE: logical = 11'd896;
                default: logical = 11'd1023;
            endcase
        end else begin
            case (size_code)
                4'h0: logical = 11'd8;
                4'h1: logical = 11'd16;
                4'h2: logical = 11'd32;
                4'h3: logical = 11'd64;
                default: logical = 11'd0;
            endcase
        end
        if (!en)
            phys_bytes = 12'h000;
        else if (dbl)
            phys_bytes = {logical, 1'b0};
        else
            phys_bytes = {1'b0, logical};
    end
endmodule

/* src/uefm_top.v */
// Purpose: endpoint layer: config, fifo allocation, event flags, buffer commands, dma select
// Assumes: serial engine events arrive as clk-domain pulses; dma pins are asynchronous
// Notes: buffer data path itself is outside; only occupancy and allocation live here
`timescale 1ns/10ps
`include "uefm_map.vh"
module uefm_top #(
    parameter NUM_EP = `UEFM_NUM_EP
) (
    input  wire        clk,
    input  wire        reset_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        dma_ack_in,
    input  wire        transfer_end_in,
    input  wire        dma_rd_strobe_n,
    input  wire        dma_wr_strobe_n,
    output reg         dma_request_out,
    output reg         dma_data_strobe,
    output reg         dma_dir_write,
    output reg         tx_ready_ff,
    output reg         alloc_overflow_ff
);
    // endpoint config regs; index 0 is control out, 1 control in, 2..15 configurable
    reg [7:0]  endpoint_config_reg [0:NUM_EP-1];
    reg [NUM_EP-1:0] endpoint_event_flag;
    reg [NUM_EP-1:0] buf_full_ff;
    reg [NUM_EP-1:0] alt_buf_ff;
    reg [NUM_EP-1:0] short_ff;
    reg        setup_lock_ff;
    reg [1:0]  setup_ack_ff;
    reg [7:0]  dma_cfg_ff;
    reg [3:0]  hw_cfg_ff;
    reg [11:0] base_ff [0:NUM_EP-1];
    reg [11:0] total_ff;
    reg [7:0]  ser_evt_ff;
    reg        ack_s1_ff, ack_s2_ff, fin_s1_ff, fin_s2_ff;
    reg        rd_s1_ff, rd_s2_ff, wr_s1_ff, wr_s2_ff;
    reg        strobe_d_ff;
    reg [4:0]  burst_cnt_ff;
    wire [11:0] phys [0:NUM_EP-1];
    // sums wider than the memory so an oversized config cannot wrap
    wire [15:0] run  [0:NUM_EP];
    integer i;

    // size decode per configurable endpoint; control pair fixed at 64
    assign run[0] = 16'h0000;
    genvar g;
    generate
        for (g = 0; g < NUM_EP; g = g + 1) begin : g_ep
            if (g < 2) begin : g_ctl
                assign phys[g] = `UEFM_CTRL_SIZE;
            end else begin : g_cfg
                uefm_size_dec u_dec (
                    .size_code  (endpoint_config_reg[g][`UEFM_EPC_SIZE_MSB:`UEFM_EPC_SIZE_LSB]),
                    .iso        (endpoint_config_reg[g][`UEFM_EPC_ISO]),
                    .dbl        (endpoint_config_reg[g][`UEFM_EPC_DBLBUF]),
                    .en         (endpoint_config_reg[g][`UEFM_EPC_EN]),
                    .phys_bytes (phys[g])
                );
            end
            assign run[g+1] = run[g] + {4'h0, phys[g]};
        end
    endgenerate

    // apb decode
    wire        acc     = psel & penable;
    wire        wr_acc  = acc & pwrite;
    wire        rd_acc  = acc & ~pwrite;
    wire        in_epc  = (paddr[11:6] == 6'h00);
    wire        in_eps  = (paddr[11:6] == 6'h01);
    wire [3:0]  reg_ep  = paddr[5:2];
    wire        mapped  = in_epc | in_eps | (paddr == `UEFM_INT_FLAGS) | (paddr == `UEFM_CMD) |
                          (paddr == `UEFM_DMA_CFG) | (paddr == `UEFM_HW_CFG) |
                          (paddr == `UEFM_SER_EVT) | (paddr == `UEFM_ALLOC_TOTAL);
    wire        cmd_wr  = wr_acc & (paddr == `UEFM_CMD);
    wire [3:0]  cmd_ep  = pwdata[3:0];
    wire [2:0]  cmd_op  = pwdata[6:4];
    wire        cmd_ctl = (cmd_ep[3:1] == 3'h0);
    wire        epc_wr  = wr_acc & in_epc & (reg_ep > 4'h1);
    wire        eps_rd  = rd_acc & in_eps;

    // serial engine events, written by the engine model side through a register strobe
    wire        ser_wr  = wr_acc & (paddr == `UEFM_SER_EVT);
    wire [3:0]  ser_ep  = pwdata[`UEFM_SER_EP_MSB:`UEFM_SER_EP_LSB];
    wire        ser_pkt = ser_wr & pwdata[`UEFM_SER_PKT];
    wire        setup   = ser_wr & pwdata[`UEFM_SER_SETUP];
    wire        bus_rst = ser_wr & pwdata[`UEFM_SER_BUSRST];
    // control in always transmits; its config word is fixed, not stored
    wire        ser_dir = (ser_ep == 4'h1) | endpoint_config_reg[ser_ep][`UEFM_EPC_DIR];
    // a receive endpoint takes a packet only while its buffers have room
    wire        rx_ok   = ser_pkt & ~ser_dir & ~buf_full_ff[ser_ep];
    // a transmit endpoint sends only a validated buffer
    wire        tx_done = ser_pkt & ser_dir & buf_full_ff[ser_ep];

    // dma selection; index 0 and 1 are the control pair and never selectable
    wire [3:0]  dma_idx = dma_cfg_ff[`UEFM_DMA_IDX_MSB:`UEFM_DMA_IDX_LSB];
    wire        dma_on  = dma_cfg_ff[`UEFM_DMA_EN] & (dma_idx > 4'h1) &
                          endpoint_config_reg[dma_idx][`UEFM_EPC_EN];
    wire        dma_dir = endpoint_config_reg[dma_idx][`UEFM_EPC_DIR];
    wire        ack_act = ack_s2_ff ~^ hw_cfg_ff[`UEFM_HW_ACK_HIGH];
    wire        fin_act = fin_s2_ff ~^ hw_cfg_ff[`UEFM_HW_FIN_HIGH];
    // fly-by uses the direction's strobe; ack-only mode ignores both strobes
    wire        strobe  = hw_cfg_ff[`UEFM_HW_ACK_ONLY] ? ack_act :
                          (ack_act & (dma_dir ? ~wr_s2_ff : ~rd_s2_ff));
    wire        stb_pls = strobe & ~strobe_d_ff & dma_on;
    wire        dma_end = dma_on & (fin_act | (short_ff[dma_idx] & ~dma_dir));
    wire        burst_n = dma_cfg_ff[`UEFM_DMA_BURST] ? (burst_cnt_ff == `UEFM_BURST_MAX - 5'h01)
                                                      : 1'b1;
    wire        want    = dma_on & (dma_dir ? ~buf_full_ff[dma_idx] : buf_full_ff[dma_idx]);

    // pin synchronisers; first stage only feeds the second
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // idle level of the default active-low pins: no false edge after reset
            ack_s1_ff <= 1'b1;
            ack_s2_ff <= 1'b1;
            fin_s1_ff <= 1'b1;
            fin_s2_ff <= 1'b1;
            rd_s1_ff  <= 1'b1;
            rd_s2_ff  <= 1'b1;
            wr_s1_ff  <= 1'b1;
            wr_s2_ff  <= 1'b1;
            strobe_d_ff <= 1'b0;
        end else begin
            ack_s1_ff <= dma_ack_in;
            ack_s2_ff <= ack_s1_ff;
            fin_s1_ff <= transfer_end_in;
            fin_s2_ff <= fin_s1_ff;
            rd_s1_ff  <= dma_rd_strobe_n;
            rd_s2_ff  <= rd_s1_ff;
            wr_s1_ff  <= dma_wr_strobe_n;
            wr_s2_ff  <= wr_s1_ff;
            strobe_d_ff <= strobe;
        end
    end

    // configuration, allocation and control registers
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (i = 0; i < NUM_EP; i = i + 1) begin
                endpoint_config_reg[i] <= 8'h00;
                base_ff[i] <= 12'h000;
            end
            dma_cfg_ff <= 8'h00;
            hw_cfg_ff  <= 4'h0;
            total_ff   <= 12'h000;
            ser_evt_ff <= 8'h00;
            alloc_overflow_ff <= 1'b0;
        end else begin
            if (bus_rst) begin
                for (i = 0; i < NUM_EP; i = i + 1)
                    endpoint_config_reg[i] <= 8'h00;
            end else if (epc_wr) begin
                endpoint_config_reg[reg_ep] <= pwdata[7:0];
            end
            // bases follow the config one cycle later
            for (i = 0; i < NUM_EP; i = i + 1)
                base_ff[i] <= run[i][11:0];
            // readback saturates; the flag below still sees the full sum
            total_ff <= (run[NUM_EP] > 16'h0FFF) ? 12'hFFF : run[NUM_EP][11:0];
            // overflow is only a flag; keeping within memory is firmware's job
            alloc_overflow_ff <= (run[NUM_EP] > {4'h0, `UEFM_MEM_BYTES});
            if (wr_acc && paddr == `UEFM_DMA_CFG)
                dma_cfg_ff <= pwdata[7:0];
            else if (dma_end)
                dma_cfg_ff[`UEFM_DMA_EN] <= 1'b0;
            if (wr_acc && paddr == `UEFM_HW_CFG)
                hw_cfg_ff <= pwdata[3:0];
            if (ser_wr)
                ser_evt_ff <= pwdata[7:0];
        end
    end

    // buffers, flags and setup lock
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            endpoint_event_flag <= {NUM_EP{1'b0}};
            buf_full_ff   <= {NUM_EP{1'b0}};
            alt_buf_ff    <= {NUM_EP{1'b0}};
            short_ff      <= {NUM_EP{1'b0}};
            setup_lock_ff <= 1'b0;
            setup_ack_ff  <= 2'b00;
        end else begin
            // clear by status read first so a same-cycle event wins
            if (eps_rd)
                endpoint_event_flag[reg_ep] <= 1'b0;
            if (rx_ok || tx_done || (setup && ser_ep == 4'h0))
                endpoint_event_flag[ser_ep] <= 1'b1;
            if (rx_ok) begin
                buf_full_ff[ser_ep] <= 1'b1;
                short_ff[ser_ep]    <= pwdata[`UEFM_SER_SHORT];
            end
            if (tx_done) begin
                buf_full_ff[ser_ep] <= 1'b0;
                alt_buf_ff[ser_ep]  <= ~alt_buf_ff[ser_ep];
            end
            if (cmd_wr) begin
                case (cmd_op)
                    `UEFM_OP_CLEAR: begin
                        if (!(cmd_ctl && setup_lock_ff)) begin
                            buf_full_ff[cmd_ep] <= 1'b0;
                            short_ff[cmd_ep]    <= 1'b0;
                            alt_buf_ff[cmd_ep]  <= ~alt_buf_ff[cmd_ep];
                        end
                    end
                    `UEFM_OP_VALIDATE: begin
                        if (!(cmd_ctl && setup_lock_ff))
                            buf_full_ff[cmd_ep] <= 1'b1;
                    end
                    `UEFM_OP_SETUP_ACK: begin
                        if (cmd_ctl) begin
                            setup_ack_ff[cmd_ep[0]] <= 1'b1;
                            if (setup_ack_ff[~cmd_ep[0]])
                                setup_lock_ff <= 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            // dma strobes: receive side drains; transmit side full flag is left to the validate command
            if (stb_pls && burst_n && !dma_dir)
                buf_full_ff[dma_idx] <= 1'b0;
            if (setup && ser_ep == 4'h0) begin
                setup_lock_ff  <= 1'b1;
                setup_ack_ff   <= 2'b00;
                buf_full_ff[1] <= 1'b0;
                buf_full_ff[0] <= 1'b1;
            end
            if (bus_rst) begin
                buf_full_ff   <= {NUM_EP{1'b0}};
                setup_lock_ff <= 1'b0;
            end
        end
    end

    // dma pins
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dma_request_out <= 1'b0;
            dma_data_strobe <= 1'b0;
            dma_dir_write   <= 1'b0;
            burst_cnt_ff    <= 5'h00;
            tx_ready_ff     <= 1'b0;
        end else begin
            // request drops after each word in single mode, after the burst otherwise
            if (stb_pls)
                burst_cnt_ff <= burst_n ? 5'h00 : burst_cnt_ff + 5'h01;
            dma_request_out <= (want & ~(stb_pls & burst_n) & ~dma_end) ^
                               ~hw_cfg_ff[`UEFM_HW_REQ_HIGH];
            dma_data_strobe <= stb_pls;
            dma_dir_write   <= dma_dir;
            tx_ready_ff     <= |buf_full_ff[NUM_EP-1:1];
        end
    end

    // apb read path; always zero wait state
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                if (in_epc)
                    prdata <= {24'h00_0000, (reg_ep < 4'h2) ? 8'h83 :
                               endpoint_config_reg[reg_ep]};
                else if (in_eps)
                    prdata <= {base_ff[reg_ep], 12'h000, 4'h0, setup_lock_ff & (reg_ep < 4'h2),
                               short_ff[reg_ep], alt_buf_ff[reg_ep], buf_full_ff[reg_ep]};
                else if (paddr == `UEFM_INT_FLAGS)
                    prdata <= {16'h0000, endpoint_event_flag};
                else if (paddr == `UEFM_DMA_CFG)
                    prdata <= {24'h00_0000, dma_cfg_ff};
                else if (paddr == `UEFM_HW_CFG)
                    prdata <= {28'h000_0000, hw_cfg_ff};
                else if (paddr == `UEFM_SER_EVT)
                    prdata <= {24'h00_0000, ser_evt_ff};
                else if (paddr == `UEFM_ALLOC_TOTAL)
                    prdata <= {20'h0_0000, total_ff};
            end
        end
    end
endmodule

/* testbench/uefm_dmac_model.sv */
// Purpose: dma controller at the fly-by / ack-only pins
// Assumes: request, acknowledge and end pins at their reset polarity (active low)
// Notes: in ack-only mode the unused strobes toggle, so they never look quiet
`timescale 1ns/10ps
module uefm_dmac_model (
    input  wire clk,
    input  wire dma_request_out,
    input  wire dma_dir_write,
    input  wire ack_only,
    output reg  dma_ack_in,
    output reg  dma_rd_strobe_n,
    output reg  dma_wr_strobe_n,
    output reg  transfer_end_in
);
    initial begin
        dma_ack_in = 1'b1;
        dma_rd_strobe_n = 1'b1;
        dma_wr_strobe_n = 1'b1;
        transfer_end_in = 1'b1;
    end
    // one byte per pass; blind ignores the request, to probe refusals
    task run(input int n, input bit blind);
        int w;
        for (int i = 0; i < n; i++) begin
            w = 0;
            while (!blind && dma_request_out !== 1'b0 && w < 64) begin
                @(posedge clk);
                w++;
            end
            for (int c = 0; c < 8; c++) begin
                @(posedge clk);
                dma_ack_in <= (c >= 4);
                if (ack_only) begin
                    dma_rd_strobe_n <= ~dma_rd_strobe_n;
                    dma_wr_strobe_n <= ~dma_wr_strobe_n;
                end else begin
                    dma_rd_strobe_n <= !(c == 1 || c == 2) || dma_dir_write;
                    dma_wr_strobe_n <= !(c == 1 || c == 2) || !dma_dir_write;
                end
            end
        end
    endtask
    task stop;
        @(posedge clk);
        transfer_end_in <= 1'b0;
        repeat (4) @(posedge clk);
        transfer_end_in <= 1'b1;
    endtask
endmodule

/* testbench/uefm_top_asserts.sv */
// Purpose: port-level checker for the endpoint fifo manager
// Assumes: apb answers in the access cycle; reset_n async active low
// Notes: bound to every uefm_top instance
`timescale 1ns/10ps
module uefm_top_asserts #(
    parameter NUM_EP = 16
) (
    input wire        clk,
    input wire        reset_n,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        dma_data_strobe,
    input wire        alloc_overflow_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing in access cycle");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access cycle");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_unmapped_refused: assert property (psel && !penable && paddr >= 12'h098
        |=> pslverr && prdata == 32'h0000_0000) else $error("unmapped access not refused");
    a_ctrl_cfg_fixed: assert property (psel && !penable && !pwrite && paddr < 12'h008
        |=> prdata == 32'h0000_0083 && !pslverr) else $error("control config not fixed");
    a_alloc_flag_match: assert property (pready && !pwrite && paddr == 12'h094
        |-> $past(alloc_overflow_ff) == (prdata > 32'h0000_099E)) else $error("overflow flag wrong");
    a_ctrl_space_kept: assert property (pready && !pwrite && paddr == 12'h094
        |-> prdata >= 32'h0000_0080) else $error("control fifos not counted");
    a_strobe_pulse: assert property (dma_data_strobe |=> !dma_data_strobe)
        else $error("dma strobe longer than one cycle");
    c_refused: cover property (pready && pslverr);
    c_overflow: cover property (alloc_overflow_ff);
    c_dma_strobe: cover property ($rose(dma_data_strobe));
endmodule
bind uefm_top uefm_top_asserts #(.NUM_EP(NUM_EP)) u_chk (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dma_data_strobe(dma_data_strobe),
    .alloc_overflow_ff(alloc_overflow_ff));

/* testbench/uefm_top_tb.sv */
// Purpose: self-checking bench for the endpoint fifo manager
// Assumes: apb answers in the access cycle
// Notes: dma pins come from the controller model
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %s exp %h got %h", n, e, g); end end
module uefm_top_tb;
    logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, err, ack_only;
    logic [11:0] paddr, ni, b;
    logic [31:0] pwdata, prdata, rv;
    wire         dma_ack_in, transfer_end_in, dma_rd_strobe_n, dma_wr_strobe_n;
    logic        dma_request_out, dma_data_strobe, dma_dir_write, tx_ready_ff;
    logic        alloc_overflow_ff;
    int          fail_count = 0, num_checks = 0, cycles = 0, scnt = 0;
    logic [11:0] iso_sz [16] = '{12'h010, 12'h020, 12'h030, 12'h040, 12'h060, 12'h080,
        12'h0A0, 12'h0C0, 12'h100, 12'h140, 12'h180, 12'h200, 12'h280, 12'h300, 12'h380,
        12'h3FF};
    uefm_top uut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .dma_ack_in, .transfer_end_in, .dma_rd_strobe_n, .dma_wr_strobe_n,
        .dma_request_out, .dma_data_strobe, .dma_dir_write, .tx_ready_ff, .alloc_overflow_ff);
    uefm_dmac_model dmac (.clk, .dma_request_out, .dma_dir_write, .ack_only, .dma_ack_in,
        .dma_rd_strobe_n, .dma_wr_strobe_n, .transfer_end_in);
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task t_reset;
        wr(12'h000, 32'h0000_0000);
        `CHK("req idle", 1'b1, dma_request_out)
        rd(12'h000);
        `CHK("ctrl out cfg", 32'h0000_0083, rv)
        rd(12'h004);
        `CHK("ctrl in cfg", 32'h0000_0083, rv)
        rd(12'h014);
        `CHK("ep cfg", 32'h0000_0000, rv)
        rd(12'h094);
        `CHK("total", 32'h0000_0080, rv)
        rd(12'h098);
        `CHK("unmapped", 33'h0_0000_0001, {rv, err})
    endtask
    task t_sizes;
        for (int c = 0; c < 16; c++) begin
            ni = (c < 4) ? (12'h008 << c) : 12'h000;
            wr(12'h008, 32'h0000_0080 | c);
            rd(12'h094);
            `CHK("plain size", 32'(12'h080 + ni), rv)
            wr(12'h008, 32'h0000_0090 | c);
            rd(12'h094);
            `CHK("iso size", 32'(12'h080 + iso_sz[c]), rv)
            wr(12'h008, 32'h0000_00B0 | c);
            rd(12'h094);
            `CHK("double size", 32'(12'h080 + (iso_sz[c] << 1)), rv)
        end
        wr(12'h008, 32'h0000_001F);
        rd(12'h094);
        `CHK("disabled size", 32'h0000_0080, rv)
    endtask
    task t_alloc;
        wr(12'h008, 32'h0000_00BF);
        wr(12'h00C, 32'h0000_009F);
        rd(12'h094);
        `CHK("over total", 32'h0000_0C7D, rv)
        `CHK("over flag", 1'b1, alloc_overflow_ff)
        wr(12'h00C, 32'h0000_0000);
        wr(12'h008, 32'h0000_0083);
        wr(12'h010, 32'h0000_0081);
        wr(12'h014, 32'h0000_00A0);
        `CHK("flag clear", 1'b0, alloc_overflow_ff)
        rd(12'h048);
        b = rv[31:20];
        rd(12'h050);
        `CHK("base skip", b + 12'h040, rv[31:20])
        rd(12'h054);
        `CHK("base next", b + 12'h050, rv[31:20])
    endtask
    task t_events;
        wr(12'h090, 32'h0000_0012);
        rd(12'h080);
        `CHK("flag set", 1'b1, rv[2])
        rd(12'h048);
        `CHK("rx full", 1'b1, rv[0])
        rd(12'h080);
        `CHK("flag read clr", 1'b0, rv[2])
        wr(12'h090, 32'h0000_0012);
        rd(12'h080);
        `CHK("full refuses", 1'b0, rv[2])
        wr(12'h084, 32'h0000_0032);
        rd(12'h048);
        `CHK("rx cleared", 1'b0, rv[0])
    endtask
    task t_tx;
        wr(12'h010, 32'h0000_00C1);
        wr(12'h084, 32'h0000_0024);
        rd(12'h050);
        `CHK("tx unvalidated", 2'b00, {rv[0], tx_ready_ff})
        wr(12'h084, 32'h0000_0044);
        rd(12'h050);
        `CHK("tx validated", 2'b11, {rv[0], tx_ready_ff})
    endtask
    task t_setup;
        wr(12'h084, 32'h0000_0041);
        wr(12'h090, 32'h0000_0030);
        rd(12'h044);
        `CHK("in flushed", 2'b10, {rv[3], rv[0]})
        wr(12'h084, 32'h0000_0030);
        wr(12'h084, 32'h0000_0050);
        wr(12'h084, 32'h0000_0030);
        rd(12'h040);
        `CHK("clear locked", 1'b1, rv[0])
        wr(12'h084, 32'h0000_0051);
        wr(12'h084, 32'h0000_0030);
        rd(12'h040);
        `CHK("clear unlocked", 2'b00, {rv[3], rv[0]})
        wr(12'h090, 32'h0000_0040);
        rd(12'h010);
        `CHK("bus reset cfg", 32'h0000_0000, rv)
    endtask
    task dma_try(input int n, input bit blind, input int exp);
        scnt = 0;
        dmac.run(n, blind);
        repeat (2) @(posedge clk);
        `CHK("dma strobes", exp, scnt)
    endtask
    task t_dma;
        for (int e = 0; e < 16; e++)
            wr(12'(4 * e), (e == 2) ? 32'h0000_00C3 : 32'h0000_0000);
        wr(12'h084, 32'h0000_0041);
        wr(12'h088, 32'h0000_0021);
        @(posedge clk);
        `CHK("dir in", 1'b1, dma_dir_write)
        dma_try(3, 1'b0, 3);
        wr(12'h088, 32'h0000_0023);
        dma_try(16, 1'b0, 16);
        wr(12'h08C, 32'h0000_0001);
        ack_only <= 1'b1;
        dma_try(2, 1'b0, 2);
        wr(12'h08C, 32'h0000_0000);
        ack_only <= 1'b0;
        wr(12'h088, 32'h0000_0020);
        dma_try(2, 1'b1, 0);
        wr(12'h088, 32'h0000_0011);
        dma_try(2, 1'b1, 0);
        wr(12'h088, 32'h0000_0021);
        wr(12'h008, 32'h0000_0083);
        @(posedge clk);
        `CHK("dir out", 1'b0, dma_dir_write)
        dmac.stop;
        rd(12'h088);
        `CHK("end clears en", 1'b0, rv[0])
        wr(12'h08C, 32'h0000_0002);
        @(posedge clk);
        `CHK("req level", 1'b0, dma_request_out)
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        if (dma_data_strobe === 1'b1)
            scnt <= scnt + 1;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            summarize;
        end
    end
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        reset_n = 1'b0;
        {psel, penable, pwrite, ack_only} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        t_reset;
        t_sizes;
        t_alloc;
        t_events;
        t_tx;
        t_setup;
        t_dma;
        summarize;
    end
endmodule
